// ==== hw/swfs_pkg.sv ====
// Purpose: Shared constants of the scan watchdog and fault supervisor
// Assumes: 20 MHz system clock, 32-bit Avalon-MM register bus
// Notes:   Byte offsets are word aligned
package swfs_pkg;
   // ****************************************
   // Clock and time base
   // ****************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int MS_NS         = 1000000;
   localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [5:0] OFS_CTRL     = 6'h00;
   localparam logic [5:0] OFS_WDT_MS   = 6'h04;
   localparam logic [5:0] OFS_CYCLE_MS = 6'h08;
   localparam logic [5:0] OFS_FILTER   = 6'h0c;
   localparam logic [5:0] OFS_MODCFG   = 6'h10;
   localparam logic [5:0] OFS_STATUS   = 6'h14;
   localparam logic [5:0] OFS_HIST_CNT = 6'h18;
   localparam logic [5:0] OFS_HIST_SEL = 6'h1c;
   localparam logic [5:0] OFS_HIST_DAT = 6'h20;
   localparam logic [5:0] OFS_ELAPSED  = 6'h24;
   localparam logic [5:0] OFS_EFFTYPE  = 6'h28;

   // ****************************************
   // Control fields and reset values
   // ****************************************
   localparam int CTRL_DBG_OUT  = 0;
   localparam int CTRL_HOLD_EN  = 1;
   localparam int CTRL_ARITH_STOP = 2;
   localparam logic [2:0]  CTRL_RST     = 3'h0;
   localparam logic [10:0] WDT_MS_MIN   = 11'h00a;
   localparam logic [10:0] WDT_MS_MAX   = 11'h3e8;
   localparam logic [10:0] WDT_MS_RST   = 11'h1f4;
   localparam logic [9:0]  CYC_MS_MIN   = 10'h001;
   localparam logic [9:0]  CYC_MS_MAX   = 10'h3e7;
   localparam logic [9:0]  CYC_MS_RST   = 10'h00a;
   localparam logic [2:0]  FILTER_RST   = 3'h1;
   localparam logic [7:0]  MODCFG_RST   = 8'h00;

   // ****************************************
   // Status bits and history codes
   // ****************************************
   localparam int ST_OVERRUN  = 0;
   localparam int ST_ARITH    = 1;
   localparam int ST_TYPE     = 2;
   localparam int ST_HW       = 3;
   localparam int ST_WARN     = 4;
   localparam int ST_IOFAIL   = 5;
   localparam int ST_HALT     = 6;
   localparam int ST_ARITH_P  = 7;
   localparam int NUM_FLAGS   = 6;
   localparam int HIST_DEPTH  = 100;
   localparam logic [6:0] HIST_LAST = 7'h63;
endpackage

// ==== hw/swfs_ms_tick.sv ====
// Purpose: Divider giving a one-cycle enable once per millisecond
// Assumes: Single clock domain
// Notes:   Free running from reset
`timescale 1ns/1ns
`default_nettype none
module swfs_ms_tick #(
   parameter int CYC_PER_MS = 20000
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Millisecond enable
   output logic      msTick
);
   logic [31:0] divQ;

   // ****************************************
   // Divider
   // ****************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         divQ   <= 32'h0;
         msTick <= 1'b0;
      end else if (divQ == 32'(CYC_PER_MS - 1)) begin
         divQ   <= 32'h0;
         msTick <= 1'b1;
      end else begin
         divQ   <= divQ + 32'h1;
         msTick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== hw/swfs_supervisor.sv ====
// Purpose: Scan watchdog, failure classifier and error history
// Assumes: Scan executor gives scan boundary and fault pulses on clk
// Notes:   Registers over Avalon-MM, one wait state per access
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module swfs_supervisor
   import swfs_pkg::*;
#(
   parameter int CYC_PER_MS_P = CYC_PER_MS,
   parameter int NSLOT        = 8
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // Avalon-MM slave
   input  wire logic [5:0]        address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   input  wire logic [3:0]        byteenable,
   output logic [31:0]            readdata,
   output logic                   waitrequest,
   // Scan executor
   input  wire logic              runMode,
   input  wire logic              stopMode,
   input  wire logic              debugMode,
   input  wire logic              scanStart,
   input  wire logic              wdtRestart,
   input  wire logic              arithFault,
   // Failure sources
   input  wire logic              hwFault,
   input  wire logic              batteryLow,
   input  wire logic              ioCtrlFail,
   input  wire logic [7:0]        instModType,
   input  wire logic [NSLOT-1:0]  modHoldCfg,
   // Supervisor outputs
   output logic                   haltExec,
   output logic                   outDriveEn,
   output logic                   outClear,
   output logic [NSLOT-1:0]       holdSlots,
   output logic                   scanOverrunFlag,
   output logic                   arithFaultPulse,
   output logic                   warnFlag,
   output logic                   cycleTick,
   output logic [6:0]             filterMs
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [6:0] filt_ms(input logic [2:0] code);
      unique case (code)
         3'h0:    filt_ms = 7'h01;
         3'h1:    filt_ms = 7'h03;
         3'h2:    filt_ms = 7'h05;
         3'h3:    filt_ms = 7'h0a;
         3'h4:    filt_ms = 7'h14;
         3'h5:    filt_ms = 7'h46;
         default: filt_ms = 7'h64;
      endcase
   endfunction

   function automatic logic [6:0] hist_wrap(input logic [7:0] v);
      hist_wrap = (v > {1'b0, HIST_LAST}) ? 7'(v - 8'd100) : v[6:0];
   endfunction

   logic                msTick;
   logic [2:0]          ctrlQ;
   logic [10:0]         wdtMsQ;
   logic [9:0]          cycMsQ;
   logic [2:0]          filtQ;
   logic [7:0]          modCfgQ;
   logic [7:0]          learnTypeQ;
   logic                learnedQ;
   logic [10:0]         elapsedQ;
   logic [9:0]          cycCntQ;
   logic [NUM_FLAGS-1:0] flagQ;
   logic [NUM_FLAGS-1:0] setFlag;
   logic                ackQ;
   logic                wrEn;
   logic                rdEn;
   logic [7:0]          effType;
   logic                typeMismatch;
   logic                overrun;
   logic                stopCause;
   logic [7:0]          hist [HIST_DEPTH];
   logic [6:0]          wrPtrQ;
   logic [6:0]          histCntQ;
   logic [6:0]          histSelQ;
   logic [7:0]          newCode;

   swfs_ms_tick #(
      .CYC_PER_MS (CYC_PER_MS_P)
   ) u_tick (
      .clk    (clk),
      .resetn (resetn),
      .msTick (msTick)
   );

   // ****************************************
   // Bus handshake
   // ****************************************
   // Every access is answered one cycle after it is raised
   assign waitrequest = (read | write) & ~ackQ;
   assign wrEn        = write & ackQ & byteenable[0];
   assign rdEn        = read & ~ackQ;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ackQ <= 1'b0;
      end else begin
         ackQ <= (read | write) & ~ackQ;
      end
   end

   // ****************************************
   // Configuration registers
   // ****************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrlQ   <= CTRL_RST;
         wdtMsQ  <= WDT_MS_RST;
         cycMsQ  <= CYC_MS_RST;
         filtQ   <= FILTER_RST;
         modCfgQ <= MODCFG_RST;
      end else if (wrEn && byteenable[0]) begin
         unique case (address)
            OFS_CTRL: ctrlQ <= writedata[2:0];
            OFS_WDT_MS: begin
               if (writedata[31:0] < 32'(WDT_MS_MIN)) begin
                  wdtMsQ <= WDT_MS_MIN;
               end else if (writedata[31:0] > 32'(WDT_MS_MAX)) begin
                  wdtMsQ <= WDT_MS_MAX;
               end else begin
                  wdtMsQ <= writedata[10:0];
               end
            end
            OFS_CYCLE_MS: begin
               if (writedata[31:0] < 32'(CYC_MS_MIN)) begin
                  cycMsQ <= CYC_MS_MIN;
               end else if (writedata[31:0] > 32'(CYC_MS_MAX)) begin
                  cycMsQ <= CYC_MS_MAX;
               end else begin
                  cycMsQ <= writedata[9:0];
               end
            end
            OFS_FILTER: begin
               if (writedata[2:0] != 3'h7) begin
                  filtQ <= writedata[2:0];
               end
            end
            OFS_MODCFG: modCfgQ <= writedata[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         filterMs <= 7'h03;
      end else begin
         filterMs <= filt_ms(filtQ);
      end
   end

   // ****************************************
   // Module identity
   // ****************************************
   // Learn the installed identity at the first run scan
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         learnTypeQ <= 8'h00;
         learnedQ   <= 1'b0;
      end else if (stopMode) begin
         learnedQ <= 1'b0;
      end else if (runMode && scanStart && !learnedQ) begin
         learnTypeQ <= instModType;
         learnedQ   <= 1'b1;
      end
   end

   assign effType = (modCfgQ != 8'h00) ? modCfgQ : learnTypeQ;
   // Type mismatch against configured or learned type
   assign typeMismatch = runMode && (modCfgQ != 8'h00 || learnedQ) && (instModType != effType);

   // ****************************************
   // Scan watchdog
   // ****************************************
   // Comparison uses the count before the increment so a trip lands exactly past the limit
   assign overrun = runMode && !haltExec && (elapsedQ > wdtMsQ);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         elapsedQ <= 11'h000;
      end else if (scanStart || wdtRestart || !runMode) begin
         elapsedQ <= 11'h000;
      end else if (msTick && !haltExec && elapsedQ != 11'h7ff) begin
         elapsedQ <= elapsedQ + 11'h001;
      end
   end

   // ****************************************
   // Fixed cycle period
   // ****************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cycCntQ   <= 10'h000;
         cycleTick <= 1'b0;
      end else if (!runMode || haltExec) begin
         cycCntQ   <= 10'h000;
         cycleTick <= 1'b0;
      end else if (msTick && cycCntQ >= cycMsQ - 10'h001) begin
         cycCntQ   <= 10'h000;
         cycleTick <= 1'b1;
      end else begin
         cycCntQ   <= msTick ? cycCntQ + 10'h001 : cycCntQ;
         cycleTick <= 1'b0;
      end
   end

   // ****************************************
   // Failure flags
   // ****************************************
   always_comb begin
      setFlag = '0;
      setFlag[ST_OVERRUN] = overrun;
      setFlag[ST_ARITH]   = runMode & arithFault;
      setFlag[ST_TYPE]    = typeMismatch;
      setFlag[ST_HW]      = hwFault;
      setFlag[ST_WARN]    = batteryLow;
      setFlag[ST_IOFAIL]  = runMode & ioCtrlFail;
   end

   assign stopCause = overrun | typeMismatch | hwFault | (runMode & ioCtrlFail)
                    | (runMode & arithFault & ctrlQ[CTRL_ARITH_STOP]);

   // Sticky flags, set wins over the stop clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flagQ <= '0;
      end else begin
         flagQ <= (stopMode ? '0 : flagQ) | setFlag;
      end
   end

   // Halt latched until STOP mode or power
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         haltExec <= 1'b0;
      end else if (stopCause) begin
         haltExec <= 1'b1;
      end else if (stopMode) begin
         haltExec <= 1'b0;
      end
   end

   // High from the fault until the next scan boundary
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         arithFaultPulse <= 1'b0;
      end else if (runMode && arithFault) begin
         arithFaultPulse <= 1'b1;
      end else if (scanStart || stopMode) begin
         arithFaultPulse <= 1'b0;
      end
   end

   // ****************************************
   // Output policy
   // ****************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         outDriveEn      <= 1'b0;
         outClear        <= 1'b0;
         holdSlots       <= '0;
         scanOverrunFlag <= 1'b0;
         warnFlag        <= 1'b0;
      end else begin
         outDriveEn <= runMode && !haltExec && (!debugMode || ctrlQ[CTRL_DBG_OUT]);
         outClear   <= haltExec && !ctrlQ[CTRL_HOLD_EN];
         holdSlots  <= (haltExec && ctrlQ[CTRL_HOLD_EN]) ? modHoldCfg : '0;
         scanOverrunFlag <= flagQ[ST_OVERRUN];
         warnFlag        <= flagQ[ST_WARN];
      end
   end

   // ****************************************
   // Error history
   // ****************************************
   // Lowest new flag wins when several rise together; the rest are set in flagQ but never logged
   always_comb begin
      newCode = 8'h00;
      for (int i = NUM_FLAGS - 1; i >= 0; i--) begin
         if (setFlag[i] && !flagQ[i]) begin
            newCode = 8'(i + 1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (newCode != 8'h00) begin
         hist[(wrEn && address == OFS_HIST_CNT) ? 7'h00 : wrPtrQ] <= newCode;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wrPtrQ   <= 7'h00;
         histCntQ <= 7'h00;
      // Delete erases all, keeps a same-cycle entry
      end else if (wrEn && address == OFS_HIST_CNT) begin
         wrPtrQ   <= (newCode != 8'h00) ? 7'h01 : 7'h00;
         histCntQ <= (newCode != 8'h00) ? 7'h01 : 7'h00;
      end else if (newCode != 8'h00) begin
         wrPtrQ   <= hist_wrap({1'b0, wrPtrQ} + 8'h01);
         histCntQ <= (histCntQ == 7'(HIST_DEPTH)) ? histCntQ : histCntQ + 7'h01;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         histSelQ <= 7'h00;
      end else if (wrEn && address == OFS_HIST_SEL) begin
         histSelQ <= (writedata[6:0] > HIST_LAST) ? HIST_LAST : writedata[6:0];
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         readdata <= 32'h0;
      end else if (rdEn) begin
         unique case (address)
            OFS_CTRL:     readdata <= {29'h0, ctrlQ};
            OFS_WDT_MS:   readdata <= {21'h0, wdtMsQ};
            OFS_CYCLE_MS: readdata <= {22'h0, cycMsQ};
            OFS_FILTER:   readdata <= {29'h0, filtQ};
            OFS_MODCFG:   readdata <= {24'h0, modCfgQ};
            OFS_STATUS:   readdata <= {24'h0, arithFaultPulse, haltExec, flagQ};
            OFS_HIST_CNT: readdata <= {25'h0, histCntQ};
            OFS_HIST_SEL: readdata <= {25'h0, histSelQ};
            OFS_HIST_DAT: begin
               if (histSelQ < histCntQ) begin
                  readdata <= {24'h0, hist[hist_wrap({1'b0, wrPtrQ} + 8'd100
                                 - {1'b0, histCntQ} + {1'b0, histSelQ})]};
               end else begin
                  readdata <= 32'h0;
               end
            end
            OFS_ELAPSED:  readdata <= {21'h0, elapsedQ};
            OFS_EFFTYPE:  readdata <= {24'h0, effType};
            default:      readdata <= 32'h0;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== verif/swfs_supervisor_assertions.sv ====
// Purpose: Port level checks of the scan supervisor
// Assumes: One clock, asynchronous active-low reset
// Notes:   Config is invisible here, so checks tie outputs to input causes
`timescale 1ns/1ns
`default_nettype none
module swfs_supervisor_chk
   import swfs_pkg::*;
#(
   parameter int CYC_PER_MS_P = CYC_PER_MS,
   parameter int NSLOT        = 8
) (
   // Clock and reset
   input wire logic             clk,
   input wire logic             resetn,
   // Bus
   input wire logic             read,
   input wire logic             write,
   input wire logic             waitrequest,
   // Executor and failures
   input wire logic             runMode,
   input wire logic             stopMode,
   input wire logic             scanStart,
   input wire logic             arithFault,
   input wire logic             hwFault,
   input wire logic             batteryLow,
   input wire logic             ioCtrlFail,
   // Outputs
   input wire logic             haltExec,
   input wire logic             outDriveEn,
   input wire logic             outClear,
   input wire logic [NSLOT-1:0] holdSlots,
   input wire logic             scanOverrunFlag,
   input wire logic             arithFaultPulse,
   input wire logic             warnFlag,
   input wire logic             cycleTick,
   input wire logic [6:0]       filterMs
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   bus_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("wait state not one cycle");
   halt_sticky_a: assert property (haltExec && !stopMode |=> haltExec)
      else $error("halt dropped without stop");
   stop_clear_a: assert property (stopMode && !runMode && !hwFault |=> !haltExec)
      else $error("stop did not clear halt");
   hw_stop_a: assert property (hwFault |=> haltExec)
      else $error("hw fault did not halt");
   io_stop_a: assert property (ioCtrlFail && runMode |=> haltExec)
      else $error("io failure did not halt");
   warn_set_a: assert property (batteryLow && !stopMode |-> ##[1:2] warnFlag)
      else $error("no warning on minor failure");
   ovr_halt_a: assert property ($rose(scanOverrunFlag) |-> haltExec)
      else $error("overrun without halt");
   drive_gate_a: assert property (outDriveEn |-> $past(runMode) && !$past(haltExec))
      else $error("outputs driven while stopped");
   clear_excl_a: assert property (outClear |-> holdSlots == '0 && $past(haltExec))
      else $error("clear and hold together");
   hold_src_a: assert property (holdSlots != '0 |-> $past(haltExec))
      else $error("hold without halt");
   arith_set_a: assert property (arithFault && runMode |=> arithFaultPulse)
      else $error("arith pulse missing");
   arith_keep_a: assert property (arithFaultPulse && !scanStart && !stopMode |=> arithFaultPulse)
      else $error("arith pulse ended early");
   arith_end_a: assert property (scanStart && !arithFault |=> !arithFaultPulse)
      else $error("arith pulse past scan end");
   filt_set_a: assert property (filterMs inside {7'h01, 7'h03, 7'h05, 7'h0a, 7'h14, 7'h46, 7'h64})
      else $error("filter time off the list");
   tick_run_a: assert property (cycleTick |-> $past(runMode))
      else $error("cycle tick while not running");
   halt_c: cover property ($rose(haltExec));
   ovr_c: cover property (scanOverrunFlag);
   arith_c: cover property (arithFaultPulse && !haltExec);
   hold_c: cover property (holdSlots != '0);
endmodule
bind swfs_supervisor swfs_supervisor_chk #(.CYC_PER_MS_P(CYC_PER_MS_P), .NSLOT(NSLOT)) i_chk (
   .clk, .resetn, .read, .write, .waitrequest, .runMode, .stopMode, .scanStart,
   .arithFault, .hwFault, .batteryLow, .ioCtrlFail, .haltExec, .outDriveEn, .outClear,
   .holdSlots, .scanOverrunFlag, .arithFaultPulse, .warnFlag, .cycleTick, .filterMs);
`default_nettype wire

// ==== verif/swfs_scan_model.sv ====
// Purpose: User program scan executor model
// Assumes: Scans of 160 cycles, restart command at counts 63 and 127 of each scan
// Notes:   Fixed lengths keep the model small; kick forces one boundary
`timescale 1ns/1ns
`default_nettype none
module swfs_scan_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Program behaviour
   input  wire logic en,
   input  wire logic kick,
   input  wire logic scanOn,
   input  wire logic rstOn,
   // Executor pulses
   output logic      scanStart,
   output logic      wdtRestart
);
   // ****************************************
   // Scan sequencer
   // ****************************************
   logic [7:0] cnt_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q      <= 8'h00;
         scanStart  <= 1'h0;
         wdtRestart <= 1'h0;
      end else begin
         cnt_q      <= (!en || cnt_q == 8'h9f) ? 8'h00 : cnt_q + 8'h01;
         scanStart  <= kick || (en && scanOn && cnt_q == 8'h9f);
         wdtRestart <= en && rstOn && cnt_q[5:0] == 6'h3f;
      end
   end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Purpose: Self-checking bench of the scan supervisor
// Assumes: 1 ms shortened to 20 cycles
// Notes:   Bus answers are taken at the rising edge
`timescale 1ns/1ns
`default_nettype none
module tb;
   import swfs_pkg::*;
   // ****************************************
   // Signals and helpers
   // ****************************************
   logic        clk = 1'h0, resetn = 1'h0, read = 1'h0, write = 1'h0;
   logic [5:0]  address = 6'h00;
   logic [31:0] writedata = 32'h0, readdata, q;
   logic [3:0]  byteenable = 4'hf;
   logic        runMode = 1'h0, stopMode = 1'h0, debugMode = 1'h0, kick = 1'h0;
   logic        scanOn = 1'h0, rstOn = 1'h0, arithFault = 1'h0, hwFault = 1'h0;
   logic        batteryLow = 1'h0, ioCtrlFail = 1'h0, scanStart, wdtRestart;
   logic [7:0]  instModType = 8'h00, modHoldCfg = 8'h00, holdSlots;
   logic        waitrequest, haltExec, outDriveEn, outClear, scanOverrunFlag;
   logic        arithFaultPulse, warnFlag, cycleTick;
   logic [6:0]  filterMs;
   int          n_fail = 0, samples_checked = 0, n, i, k;
   logic [6:0]  ftab [7] = '{7'h01, 7'h03, 7'h05, 7'h0a, 7'h14, 7'h46, 7'h64};
   always #25 clk = ~clk;
   swfs_supervisor #(.CYC_PER_MS_P(20), .NSLOT(8)) i_dut (.clk, .resetn, .address, .read,
      .write, .writedata, .byteenable, .readdata, .waitrequest, .runMode, .stopMode,
      .debugMode, .scanStart, .wdtRestart, .arithFault, .hwFault, .batteryLow, .ioCtrlFail,
      .instModType, .modHoldCfg, .haltExec, .outDriveEn, .outClear, .holdSlots,
      .scanOverrunFlag, .arithFaultPulse, .warnFlag, .cycleTick, .filterMs);
   swfs_scan_model i_prog (.clk, .resetn, .en(runMode), .kick, .scanOn, .rstOn, .scanStart,
      .wdtRestart);
   task results;
      if (n_fail == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task acc(input logic w, input logic [5:0] a, input logic [31:0] d);
      int  c;
      logic wt;
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      c = 0;
      do begin
         @(posedge clk);
         wt = waitrequest;
         q = readdata;
         c++;
      end while (wt !== 1'h0 && c < 20);
      write <= 1'h0;
      read <= 1'h0;
      if (wt !== 1'h0) begin
         chk(wt, 0, "bus hang");
         results();
      end
   endtask
   task wr(input logic [5:0] a, input logic [31:0] d);
      acc(1'h1, a, d);
   endtask
   task rd(input logic [5:0] a, input logic [31:0] e, input string m);
      acc(1'h0, a, 32'h0);
      chk(q, e, m);
   endtask
   task wh(input int lim);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (haltExec !== 1'h1 && n < lim);
   endtask
   task run;
      @(posedge clk);
      runMode <= 1'h1;
   endtask
   task stp;
      @(posedge clk);
      runMode <= 1'h0;
      stopMode <= 1'h1;
      repeat (2) @(posedge clk);
      stopMode <= 1'h0;
      @(posedge clk);
      chk(haltExec, 0, "stop clear");
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task t_reset;
      rd(OFS_CTRL, 32'h0, "ctrl");
      rd(OFS_WDT_MS, 32'h1f4, "wdt");
      rd(OFS_FILTER, 32'h1, "filter");
      chk(filterMs, 32'h3, "filter ms");
      rd(6'h3c, 32'h0, "unmapped");
      rd(OFS_HIST_CNT, 32'h0, "hist");
   endtask
   task t_cfg;
      wr(OFS_WDT_MS, 32'h5);
      rd(OFS_WDT_MS, 32'ha, "wdt low");
      wr(OFS_WDT_MS, 32'h7d0);
      rd(OFS_WDT_MS, 32'h3e8, "wdt high");
      wr(OFS_WDT_MS, 32'ha);
      wr(OFS_CYCLE_MS, 32'h0);
      rd(OFS_CYCLE_MS, 32'h1, "cyc low");
      wr(OFS_CYCLE_MS, 32'h3e8);
      rd(OFS_CYCLE_MS, 32'h3e7, "cyc high");
      for (i = 0; i < 7; i++) begin
         wr(OFS_FILTER, i);
         repeat (2) @(negedge clk);
         chk(filterMs, ftab[i], "filter");
      end
      wr(OFS_FILTER, 32'h7);
      rd(OFS_FILTER, 32'h6, "filter 7");
   endtask
   task t_ovr;
      run();
      wh(400);
      chk(n >= 200 && n <= 225, 1, "overrun time");
      @(negedge clk);
      chk(scanOverrunFlag, 1, "ovr flag");
      chk(outClear, 1, "clear");
      chk(holdSlots, 0, "no hold");
      chk(outDriveEn, 0, "drive");
      wr(OFS_STATUS, 32'hffffffff);
      rd(OFS_STATUS, 32'h41, "status");
      rd(OFS_HIST_CNT, 32'h1, "hist cnt");
      rd(OFS_HIST_DAT, 32'h1, "hist code");
      runMode <= 1'h0;
      repeat (50) @(posedge clk);
      chk(haltExec, 1, "halt kept");
      stp();
   endtask
   task t_restart;
      scanOn <= 1'h1;
      run();
      wh(700);
      chk(haltExec, 0, "scan boundary");
      scanOn <= 1'h0;
      rstOn <= 1'h1;
      wh(700);
      chk(haltExec, 0, "restart cmd");
      rstOn <= 1'h0;
      wh(400);
      chk(haltExec, 1, "no restart");
      stp();
   endtask
   task t_hold;
      wr(OFS_CTRL, 32'h2);
      modHoldCfg <= 8'ha5;
      run();
      hwFault <= 1'h1;
      @(posedge clk);
      hwFault <= 1'h0;
      repeat (2) @(negedge clk);
      chk(haltExec, 1, "hw halt");
      chk(holdSlots, 32'ha5, "hold");
      chk(outClear, 0, "no clear");
      stp();
   endtask
   task t_arith;
      wr(OFS_CTRL, 32'h1);
      debugMode <= 1'h1;
      run();
      repeat (2) @(negedge clk);
      chk(outDriveEn, 1, "dbg on");
      wr(OFS_CTRL, 32'h0);
      repeat (2) @(negedge clk);
      chk(outDriveEn, 0, "dbg off");
      debugMode <= 1'h0;
      wr(OFS_CYCLE_MS, 32'h1);
      k = 0;
      repeat (100) begin
         @(negedge clk);
         k += cycleTick;
      end
      chk(k, 5, "cycle ticks");
      @(posedge clk);
      arithFault <= 1'h1;
      @(posedge clk);
      arithFault <= 1'h0;
      @(negedge clk);
      chk(arithFaultPulse, 1, "arith pulse");
      chk(haltExec, 0, "arith go on");
      rd(OFS_STATUS, 32'h82, "arith status");
      kick <= 1'h1;
      @(posedge clk);
      kick <= 1'h0;
      repeat (2) @(negedge clk);
      chk(arithFaultPulse, 0, "pulse end");
      wr(OFS_CTRL, 32'h4);
      arithFault <= 1'h1;
      @(posedge clk);
      arithFault <= 1'h0;
      repeat (2) @(negedge clk);
      chk(haltExec, 1, "arith stop");
      stp();
   endtask
   task t_warn;
      wr(OFS_CTRL, 32'h0);
      run();
      batteryLow <= 1'h1;
      @(posedge clk);
      batteryLow <= 1'h0;
      repeat (3) @(posedge clk);
      chk(warnFlag, 1, "warn");
      chk(haltExec, 0, "warn go on");
      ioCtrlFail <= 1'h1;
      @(posedge clk);
      ioCtrlFail <= 1'h0;
      repeat (2) @(negedge clk);
      chk(haltExec, 1, "io stop");
      rd(OFS_STATUS, 32'h70, "io status");
      stp();
   endtask
   task t_type;
      instModType <= 8'h3c;
      run();
      kick <= 1'h1;
      @(posedge clk);
      kick <= 1'h0;
      rd(OFS_EFFTYPE, 32'h3c, "learned");
      chk(haltExec, 0, "type ok");
      instModType <= 8'h3d;
      repeat (3) @(negedge clk);
      chk(haltExec, 1, "type halt");
      rd(OFS_STATUS, 32'h44, "type status");
      stp();
   endtask
   task t_hist;
      wr(OFS_HIST_CNT, 32'h0);
      batteryLow <= 1'h1;
      @(posedge clk);
      batteryLow <= 1'h0;
      stp();
      repeat (100) begin
         hwFault <= 1'h1;
         @(posedge clk);
         hwFault <= 1'h0;
         stp();
      end
      rd(OFS_HIST_CNT, 32'h64, "hist full");
      wr(OFS_HIST_SEL, 32'h0);
      rd(OFS_HIST_DAT, 32'h4, "oldest lost");
      wr(OFS_HIST_SEL, 32'h63);
      rd(OFS_HIST_DAT, 32'h4, "newest");
      wr(OFS_HIST_CNT, 32'h0);
      rd(OFS_HIST_CNT, 32'h0, "hist gone");
      rd(OFS_HIST_DAT, 32'h0, "entry gone");
   endtask
   initial begin
      #5000000;
      chk(0, 1, "run timeout");
      results();
   end
   initial begin
      repeat (3) @(posedge clk);
      resetn <= 1'h1;
      t_reset();
      t_cfg();
      t_ovr();
      t_restart();
      t_hold();
      t_arith();
      t_warn();
      t_type();
      t_hist();
      results();
   end
endmodule
`default_nettype wire
